//--- src/clock_gen_pkg.sv
// constants shared by the clock generation block: register map, field
// positions, reset values, source codes and wake-up timing.
// assumes a single 125 MHz system clock; oscillators arrive as tick pulses.
package clock_gen_pkg;

	localparam int CLK_MHZ           = 125;   // system clock rate
	localparam int XTAL_EXTRA_US     = 60;    // least extra crystal settle time
	localparam int RC_WAKE_US        = 200;   // least rc oscillator settle time
	localparam int XTAL_EXTRA_CYCLES = XTAL_EXTRA_US * CLK_MHZ;
	localparam int RC_WAKE_CYCLES    = RC_WAKE_US * CLK_MHZ;
	localparam int XTAL_START_TICKS  = 1024;  // oscillator cycles before release
	localparam int SLOW_START_TICKS  = 32;    // watchdog osc and external input
	localparam int RC_NOMINAL_KHZ    = 7373;  // undoubled rc rate
	localparam int RC_DOUBLED_KHZ    = 14746; // rate of the rc tick input
	localparam int DIV_MAX_RATIO     = 510;   // largest division of osc_clock

	localparam int ADDR_W = 3;
	localparam int DATA_W = 8;

	localparam logic [ADDR_W-1:0] CTRL_OFFSET   = 3'h0; // clock_control_reg
	localparam logic [ADDR_W-1:0] DIV_OFFSET    = 3'h1; // clock_divider_reg
	localparam logic [ADDR_W-1:0] TRIM_OFFSET   = 3'h2; // trim and clock out enable
	localparam logic [ADDR_W-1:0] AUX_OFFSET    = 3'h3; // aux_control_reg
	localparam logic [ADDR_W-1:0] STATUS_OFFSET = 3'h4; // live state, read only

	localparam int CTRL_DONE_BIT   = 7;
	localparam int CTRL_XTALWD_BIT = 4;
	localparam int CTRL_DBL_BIT    = 3;
	localparam int TRIM_CLOCK_OUT_ENABLE_BIT  = 6;
	localparam int AUX_LP_BIT      = 7;
	localparam int USER_CONFIG_BYTE2_DBL_BIT   = 7;

	localparam logic [DATA_W-1:0] DIV_RESET = 8'h00;

	localparam logic [2:0] SRC_XTAL_HIGH = 3'h0;
	localparam logic [2:0] SRC_XTAL_MED  = 3'h1;
	localparam logic [2:0] SRC_XTAL_LOW  = 3'h2;
	localparam logic [2:0] SRC_RC        = 3'h3;
	localparam logic [2:0] SRC_WDOG      = 3'h4;
	localparam logic [2:0] SRC_EXT       = 3'h7;

	typedef enum logic [3:0]
	{
		KIND_XTAL = 4'h1,
		KIND_RC   = 4'h2,
		KIND_WDOG = 4'h4,
		KIND_EXT  = 4'h8
	} src_kind_type;

	typedef enum logic [5:0]
	{
		ST_LOAD     = 6'h01,
		ST_WAKE_OSC = 6'h02,
		ST_WAKE_TIM = 6'h04,
		ST_RUN      = 6'h08,
		ST_SW_OLD   = 6'h10,
		ST_SW_NEW   = 6'h20
	} clk_state_type;

endpackage : clock_gen_pkg

//--- src/system_clock_generation.sv
// clock source selection, wake-up delay, cpu clock divider and clock out.
// assumes oscillators present one-cycle tick pulses synchronous to clk_in;
// the external clock pin is a synchronous level whose rising edges count.
//
// Our own choices: the address map and the strobed register port.
module system_clock_generation
	import clock_gen_pkg::*;
#(
	parameter int XTAL_SETTLE_CYCLES = XTAL_EXTRA_CYCLES,
	parameter int RC_SETTLE_CYCLES   = RC_WAKE_CYCLES
)
(
	input  wire logic              clk_in,
	input  wire logic              arst_n_in,
	input  wire logic              full_reset_in,
	input  wire logic [7:0]        user_config_byte1_in,
	input  wire logic [7:0]        user_config_byte2_in,
	input  wire logic [5:0]        factory_trim_in,
	input  wire logic              xtal_tick_in,
	input  wire logic              rc_tick_in,
	input  wire logic              wdog_tick_in,
	input  wire logic              crystal_in_pin_in,
	input  wire logic              wake_in,
	input  wire logic [ADDR_W-1:0] reg_addr_in,
	input  wire logic [DATA_W-1:0] reg_wdata_in,
	input  wire logic              reg_wr_in,
	input  wire logic              reg_rd_in,
	output logic      [DATA_W-1:0] reg_rdata_out,
	output logic                   cpu_tick_out,
	output logic                   periph_tick_out,
	output logic                   machine_cycle_out,
	output logic                   low_power_clock_out,
	output logic      [5:0]        rc_trim_out,
	output logic                   crystal_out_pin_out,
	output logic                   crystal_out_pin_oe_out,
	output logic                   clock_switch_done_out
);

	// settle counters are 16 bits wide; larger figures cannot be served
	if (XTAL_SETTLE_CYCLES < 1 || XTAL_SETTLE_CYCLES > 65535 ||
		RC_SETTLE_CYCLES < 1 || RC_SETTLE_CYCLES > 65535)
	begin : g_bad_param
		$error("settle cycle parameter out of range");
	end

	// map a source code onto its oscillator kind; unused codes fall to rc
	function automatic src_kind_type src_kind(input logic [2:0] code);
		unique case (code)
			SRC_XTAL_HIGH, SRC_XTAL_MED, SRC_XTAL_LOW: src_kind = KIND_XTAL;
			SRC_WDOG: src_kind = KIND_WDOG;
			SRC_EXT:  src_kind = KIND_EXT;
			default:  src_kind = KIND_RC;
		endcase
	endfunction : src_kind

	clk_state_type state;
	logic [2:0]  ctrl_src;      // requested source
	logic [2:0]  active_src;    // source actually feeding osc_clock
	logic        ctrl_dbl;
	logic        ctrl_xtal_wd;
	logic        switch_done;
	logic [7:0]  clock_divider_reg;
	logic [5:0]  trim;
	logic        clock_out_enable;
	logic        low_power_clock_bit;
	logic        rc_half;
	logic        ext_pin_prev;
	logic [15:0] wake_cnt;
	logic [8:0]  div_cnt;
	logic        cpu_phase;
	logic        clk_level;
	logic        rc_tick;
	logic        ext_tick;
	logic [3:0]  kind_ticks;
	logic        osc_tick;
	logic        new_tick;
	logic        cpu_en;
	logic        cpu_tick_gen;
	logic [8:0]  div_last;
	logic        div_moved;
	logic        ctrl_wr;
	logic [15:0] osc_limit;
	logic [15:0] time_limit;
	src_kind_type active_kind;

	// rc tick input runs doubled; without the doubler every other tick passes
	assign rc_tick    = rc_tick_in & (ctrl_dbl | rc_half);
	assign ext_tick   = crystal_in_pin_in & ~ext_pin_prev;
	assign kind_ticks = {ext_tick, wdog_tick_in, rc_tick, xtal_tick_in};
	assign active_kind = src_kind(active_src);
	// exactly one kind bit is set, so one source feeds osc_clock
	assign osc_tick   = |(kind_ticks & active_kind);
	assign new_tick   = |(kind_ticks & src_kind(ctrl_src));
	assign ctrl_wr    = reg_wr_in && reg_addr_in == CTRL_OFFSET;
	// the cpu keeps the old clock until its current phase has ended
	assign cpu_en     = state == ST_RUN || state == ST_SW_OLD;

	// oscillator prescale state
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			rc_half      <= 1'b0;
			ext_pin_prev <= 1'b1; // a pin already high at release is no edge
		end
		else
		begin
			if (rc_tick_in)
				rc_half <= ~rc_half;
			ext_pin_prev <= crystal_in_pin_in;
		end
	end

	// wake-up hold figures for the active source
	always_comb
	begin
		unique case (active_kind)
			KIND_XTAL:
			begin
				osc_limit  = 16'(XTAL_START_TICKS);
				time_limit = 16'(XTAL_SETTLE_CYCLES);
			end
			KIND_RC:
			begin
				osc_limit  = 16'h0000;
				time_limit = 16'(RC_SETTLE_CYCLES);
			end
			default:
			begin
				osc_limit  = 16'(SLOW_START_TICKS);
				time_limit = 16'h0000;
			end
		endcase
	end

	// sequencing of configuration load, wake-up and source switching
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			state       <= ST_LOAD;
			wake_cnt    <= 16'h0000;
			active_src  <= SRC_RC;
			switch_done <= 1'b0;
		end
		else
		begin
			unique case (state)
				ST_LOAD:
				begin
					active_src  <= user_config_byte1_in[2:0];
					switch_done <= 1'b1;
					wake_cnt    <= 16'h0000;
					state       <= ST_WAKE_OSC;
				end
				ST_WAKE_OSC:
				begin
					if (wake_cnt >= osc_limit)
					begin
						wake_cnt <= 16'h0000;
						state    <= ST_WAKE_TIM;
					end
					else if (osc_tick)
						wake_cnt <= wake_cnt + 16'h0001;
				end
				ST_WAKE_TIM:
				begin
					if (wake_cnt >= time_limit)
						state <= ST_RUN;
					else
						wake_cnt <= wake_cnt + 16'h0001;
				end
				ST_RUN:
				begin
					if (wake_in)
					begin
						wake_cnt <= 16'h0000;
						state    <= ST_WAKE_OSC;
					end
					else if (ctrl_wr && reg_wdata_in[2:0] != active_src)
					begin
						switch_done <= 1'b0;
						state       <= ST_SW_OLD;
					end
				end
				ST_SW_OLD:
				begin
					if (osc_tick)
						state <= ST_SW_NEW;
				end
				ST_SW_NEW:
				begin
					if (new_tick)
					begin
						active_src  <= ctrl_src;
						switch_done <= 1'b1;
						state       <= ST_RUN;
					end
				end
			endcase
		end
	end

	// control register; writes are dropped while a switch is in flight
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			ctrl_src     <= SRC_RC;
			ctrl_dbl     <= 1'b0;
			ctrl_xtal_wd <= 1'b0;
		end
		else if (state == ST_LOAD)
		begin
			ctrl_src <= user_config_byte1_in[2:0];
			ctrl_dbl <= user_config_byte2_in[USER_CONFIG_BYTE2_DBL_BIT];
		end
		else if (ctrl_wr && switch_done && state == ST_RUN && !wake_in)
		begin
			ctrl_src     <= reg_wdata_in[2:0];
			ctrl_dbl     <= reg_wdata_in[CTRL_DBL_BIT];
			ctrl_xtal_wd <= reg_wdata_in[CTRL_XTALWD_BIT];
		end
	end

	// divider and low power bit; divider applies on the next osc tick
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			clock_divider_reg   <= DIV_RESET;
			low_power_clock_bit <= 1'b0;
		end
		else if (reg_wr_in)
		begin
			if (reg_addr_in == DIV_OFFSET)
				clock_divider_reg <= reg_wdata_in;
			if (reg_addr_in == AUX_OFFSET)
				low_power_clock_bit <= reg_wdata_in[AUX_LP_BIT];
		end
	end

	// trim keeps its value across resets other than power-on or watchdog,
	// so these flops are deliberately outside the asynchronous reset
	always_ff @(posedge clk_in)
	begin
		if (state == ST_LOAD && full_reset_in)
			trim <= factory_trim_in;
		else if (reg_wr_in && reg_addr_in == TRIM_OFFSET)
			trim <= reg_wdata_in[5:0];
	end

	// clock out enable lives beside trim but resets with everything else
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			clock_out_enable <= 1'b0;
		else if (reg_wr_in && reg_addr_in == TRIM_OFFSET)
			clock_out_enable <= reg_wdata_in[TRIM_CLOCK_OUT_ENABLE_BIT];
	end

	// cpu clock divider: ratio two times divider value, zero passes through
	assign div_last     = {clock_divider_reg, 1'b0} - 9'h001;
	assign cpu_tick_gen = cpu_en && osc_tick &&
		(clock_divider_reg == 8'h00 || div_cnt >= div_last);

	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			div_cnt <= 9'h000;
		else if (cpu_tick_gen)
			div_cnt <= 9'h000;
		else if (cpu_en && osc_tick)
			div_cnt <= div_cnt + 9'h001;
	end

	// marks a divider write not yet followed by a cpu tick; a shrinking
	// divider leaves the count past its new end for that one tick
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			div_moved <= 1'b0;
		else if (reg_wr_in && reg_addr_in == DIV_OFFSET)
			div_moved <= 1'b1;
		else if (cpu_tick_gen)
			div_moved <= 1'b0;
	end

	// cpu, peripheral and machine cycle pulses and the clock out level
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			cpu_tick_out      <= 1'b0;
			periph_tick_out   <= 1'b0;
			machine_cycle_out <= 1'b0;
			cpu_phase         <= 1'b0;
			clk_level         <= 1'b0;
		end
		else
		begin
			cpu_tick_out      <= cpu_tick_gen;
			periph_tick_out   <= cpu_tick_gen & cpu_phase;
			machine_cycle_out <= cpu_tick_gen & cpu_phase;
			if (cpu_tick_gen)
			begin
				cpu_phase <= ~cpu_phase;
				clk_level <= ~clk_level;
			end
		end
	end

	// pin drive is off whenever any consumer needs the crystal
	assign crystal_out_pin_oe_out = clock_out_enable && active_kind != KIND_XTAL &&
		src_kind(ctrl_src) != KIND_XTAL && !ctrl_xtal_wd;
	assign crystal_out_pin_out    = clk_level;
	assign low_power_clock_out    = low_power_clock_bit;
	assign rc_trim_out            = trim;
	assign clock_switch_done_out  = switch_done;

	// register read port, data one cycle after the strobe
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			reg_rdata_out <= 8'h00;
		else if (reg_rd_in)
		begin
			unique case (reg_addr_in)
				CTRL_OFFSET: reg_rdata_out <= {switch_done, 2'b00, ctrl_xtal_wd,
					ctrl_dbl, ctrl_src};
				DIV_OFFSET:  reg_rdata_out <= clock_divider_reg;
				TRIM_OFFSET: reg_rdata_out <= {1'b0, clock_out_enable, trim};
				AUX_OFFSET:  reg_rdata_out <= {low_power_clock_bit, 7'h00};
				STATUS_OFFSET: reg_rdata_out <= {1'b0, ~cpu_en, state};
				default:     reg_rdata_out <= 8'h00;
			endcase
		end
	end

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!arst_n_in);

	sequence switch_start;
		state == ST_RUN && ctrl_wr && switch_done && !wake_in &&
			reg_wdata_in[2:0] != active_src;
	endsequence

	sequence switch_finish;
		!switch_done [*2] ##[0:300] switch_done;
	endsequence

	chk_write_refused: assert property (!switch_done && ctrl_wr |=> $stable(ctrl_src))
		else $error("control write taken during switch");
	chk_switch_done_seq: assert property (switch_start |=> switch_finish)
		else $error("switch done not cleared then set");
	chk_clkout_gate: assert property (crystal_out_pin_oe_out |->
		clock_out_enable && !ctrl_xtal_wd && active_kind != KIND_XTAL)
		else $error("clock out driven while crystal in use");
	chk_clkout_rate: assert property ($changed(crystal_out_pin_out) |->
		$past(cpu_tick_gen))
		else $error("clock out toggled without cpu tick");
	chk_periph_half: assert property (periph_tick_out |-> cpu_tick_out &&
		machine_cycle_out ##1 !periph_tick_out)
		else $error("peripheral tick not on alternate cpu tick");
	chk_div_bypass: assert property (cpu_en && osc_tick && clock_divider_reg == 8'h00
		|=> cpu_tick_out)
		else $error("zero divider did not pass osc tick");
	chk_div_ratio: assert property (cpu_tick_gen && clock_divider_reg != 8'h00 |->
		div_cnt == div_last || div_moved)
		else $error("cpu tick at wrong divider count");
	chk_wake_hold: assert property (state == ST_WAKE_OSC || state == ST_WAKE_TIM
		|=> !cpu_tick_out)
		else $error("cpu ticked during wake-up hold");
	chk_lp_reset: assert property (state == ST_LOAD |-> !low_power_clock_bit)
		else $error("low power bit set after reset");
	chk_one_source: assert property ($onehot(active_kind))
		else $error("osc clock source not unique");

endmodule : system_clock_generation

//--- verification/osc_model.sv
// oscillator model: crystal, rc, watchdog ticks and the external clock pin.
// assumes clk_in is the system clock; every source runs free, the oscillators as tick pulses and the pin as a square wave.
module osc_model
#(
	parameter int XTAL_P = 3,
	parameter int RC_P   = 4,
	parameter int WDOG_P = 10,
	parameter int EXT_P  = 6
)
(
	input  wire logic clk_in,
	output logic      xtal_tick_out,
	output logic      rc_tick_out,
	output logic      wdog_tick_out,
	output logic      ext_pin_out
);
	timeunit 1ns;
	timeprecision 1ps;

	int xc = 0;
	int rc = 0;
	int wc = 0;
	int ec = 0;

	// free running phase counters, all starting at zero, so source ticks line up at start and every common period
	always @(posedge clk_in)
	begin
		xc <= (xc + 1) % XTAL_P;
		rc <= (rc + 1) % RC_P;
		wc <= (wc + 1) % WDOG_P;
		ec <= (ec + 1) % EXT_P;
	end

	// rc ticks come at the doubled rate; without the doubler the block drops every other one
	assign xtal_tick_out = (xc == 0);
	assign rc_tick_out   = (rc == 0);
	assign wdog_tick_out = (wc == 0);
	assign ext_pin_out   = (ec < EXT_P / 2);

endmodule : osc_model

//--- verification/system_clock_generation_tb.sv
// self-checking bench for the clock generation block.
// assumes osc_model on the tick inputs and short settle parameters.
module system_clock_generation_tb;
	import clock_gen_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int XS = 4;
	localparam int RS = 8;
	localparam int XP = 3;
	localparam int RP = 4;
	localparam int WP = 10;
	localparam int EP = 6;

	logic       clk      = 1'b0;
	logic       arst_n   = 1'b0;
	logic       full_rst = 1'b1;
	logic [7:0] cfg1     = 8'h2B;
	logic [7:0] cfg2     = 8'h80;
	logic [5:0] ftrim    = 6'h2A;
	logic       wake     = 1'b0;
	logic [2:0] addr     = 3'h0;
	logic [7:0] wdata    = 8'h00;
	logic       wr_s     = 1'b0;
	logic       rd_s     = 1'b0;
	logic [7:0] rdata;
	logic [5:0] trim;
	logic       cpu_t, per_t, mc_t, lp, pin, oe, done, xt, rt, wt, ep, prev_pin;
	int         errors   = 0;
	int         checks   = 0;
	int         p_cnt    = 0;
	int         bad_cnt  = 0;

	// 125 MHz system clock
	always #4 clk = ~clk;

	system_clock_generation #(.XTAL_SETTLE_CYCLES(XS), .RC_SETTLE_CYCLES(RS)) u_dut
	(
		.clk_in(clk), .arst_n_in(arst_n), .full_reset_in(full_rst),
		.user_config_byte1_in(cfg1), .user_config_byte2_in(cfg2), .factory_trim_in(ftrim),
		.xtal_tick_in(xt), .rc_tick_in(rt), .wdog_tick_in(wt), .crystal_in_pin_in(ep),
		.wake_in(wake), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr_s),
		.reg_rd_in(rd_s), .reg_rdata_out(rdata), .cpu_tick_out(cpu_t),
		.periph_tick_out(per_t), .machine_cycle_out(mc_t), .low_power_clock_out(lp),
		.rc_trim_out(trim), .crystal_out_pin_out(pin), .crystal_out_pin_oe_out(oe),
		.clock_switch_done_out(done)
	);

	osc_model #(.XTAL_P(XP), .RC_P(RP), .WDOG_P(WP), .EXT_P(EP)) u_osc
	(
		.clk_in(clk), .xtal_tick_out(xt), .rc_tick_out(rt), .wdog_tick_out(wt),
		.ext_pin_out(ep)
	);

	task automatic test_done;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : test_done

	task automatic cmp(input string name, input logic [15:0] exp, input logic [15:0] got);
		checks++;
		if (got !== exp)
		begin
			errors++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask : cmp

	function automatic logic [15:0] in_range(input int n, input int lo);
		return 16'(n >= lo && n < lo + 200);
	endfunction : in_range

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr_s  <= 1'b1;
		@(posedge clk);
		wr_s  <= 1'b0;
		#1;
	endtask : wr

	task automatic rdc(input string name, input logic [2:0] a, input logic [7:0] exp);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		#1 cmp(name, 16'(exp), 16'(rdata));
	endtask : rdc

	// counts edges to the next cpu tick and watches pairing and pin toggling
	task automatic wait_tick(output int n);
		n = 0;
		prev_pin = pin;
		do
		begin
			@(posedge clk);
			#1 n++;
			if (per_t === 1'b1)
				p_cnt++;
			if (mc_t !== per_t || (per_t === 1'b1 && cpu_t !== 1'b1))
				bad_cnt++;
			if (cpu_t === 1'b1 && oe === 1'b1 && pin === prev_pin)
				bad_cnt++;
			prev_pin = pin;
		end
		while (cpu_t !== 1'b1 && n < 5000);
	endtask : wait_tick

	task automatic wait_done;
		for (int i = 0; i < 300 && done !== 1'b1; i++)
		begin
			@(posedge clk);
			#1;
		end
	endtask : wait_done

	// the first two ticks after a change may be short, so the third is timed
	task automatic gap(input string name, input int exp);
		int n;
		wait_tick(n);
		wait_tick(n);
		wait_tick(n);
		cmp(name, 16'(exp), 16'(n));
	endtask : gap

	task automatic do_reset(input logic full, input logic dbl, input logic [2:0] src,
		output int n);
		@(posedge clk);
		arst_n   <= 1'b0;
		full_rst <= full;
		cfg1     <= 8'h28 | {5'h00, src};
		cfg2     <= {dbl, 7'h00};
		repeat (10) @(posedge clk);
		arst_n <= 1'b1;
		wait_tick(n);
	endtask : do_reset

	task automatic wake_chk(input string name, input int lo);
		int n;
		wait_tick(n);
		@(posedge clk);
		wake <= 1'b1;
		@(posedge clk);
		wake <= 1'b0;
		wait_tick(n);
		cmp(name, 16'h0001, in_range(n, lo));
	endtask : wake_chk

	task automatic t_reset;
		int n;
		do_reset(1'b1, 1'b1, SRC_RC, n);
		cmp("rc wake", 16'h0001, in_range(n, RS));
		rdc("ctrl", CTRL_OFFSET, 8'h8B);
		rdc("trim", TRIM_OFFSET, 8'h2A);
		cmp("trim out", 16'h002A, 16'(trim));
		rdc("aux", AUX_OFFSET, 8'h00);
		rdc("status", STATUS_OFFSET, 8'h08);
		rdc("div", DIV_OFFSET, DIV_RESET);
		wr(3'h6, 8'hFF);
		rdc("unmapped", 3'h6, 8'h00);
	endtask : t_reset

	task automatic t_divider;
		logic [7:0] divs [4] = '{8'h00, 8'h01, 8'h02, 8'hFF};
		int n;
		foreach (divs[i])
		begin
			wr(DIV_OFFSET, divs[i]);
			gap("cpu gap", (divs[i] == 8'h00) ? RP : 2 * RP * divs[i]);
		end
		wr(DIV_OFFSET, 8'h01);
		p_cnt = 0;
		bad_cnt = 0;
		repeat (8) wait_tick(n);
		cmp("periph ticks", 16'h0004, 16'(p_cnt));
		cmp("tick pairing", 16'h0000, 16'(bad_cnt));
	endtask : t_divider

	task automatic t_clock_out;
		int n;
		wr(TRIM_OFFSET, 8'h6A);
		cmp("oe enabled", 16'h0001, 16'(oe));
		bad_cnt = 0;
		repeat (4) wait_tick(n);
		cmp("pin toggle", 16'h0000, 16'(bad_cnt));
		wr(CTRL_OFFSET, 8'h1B);
		wait_done;
		cmp("oe crystal used", 16'h0000, 16'(oe));
		wr(CTRL_OFFSET, 8'h0B);
		wait_done;
		wr(TRIM_OFFSET, 8'h2A);
		cmp("oe disabled", 16'h0000, 16'(oe));
		wr(AUX_OFFSET, 8'h80);
		rdc("aux", AUX_OFFSET, 8'h80);
		cmp("low power out", 16'h0001, 16'(lp));
	endtask : t_clock_out

	// a second write lands while the switch is still running
	task automatic t_switch;
		wr(CTRL_OFFSET, 8'h0C);
		cmp("done at start", 16'h0000, 16'(done));
		wr(CTRL_OFFSET, 8'h0F);
		wait_done;
		cmp("done at end", 16'h0001, 16'(done));
		rdc("ctrl refused", CTRL_OFFSET, 8'h8C);
		gap("wdog gap", 2 * WP);
		wake_chk("wdog wake", 31 * WP);
		wr(CTRL_OFFSET, 8'h0F);
		wait_done;
		gap("ext gap", 2 * EP);
		wake_chk("ext wake", 31 * EP);
		wr(CTRL_OFFSET, 8'h0B);
		wait_done;
		gap("rc gap", 2 * RP);
		wake_chk("rc wake", RS);
	endtask : t_switch

	task automatic t_trim_keep;
		int n;
		wr(TRIM_OFFSET, 8'h15);
		do_reset(1'b0, 1'b0, SRC_RC, n);
		rdc("trim kept", TRIM_OFFSET, 8'h15);
		rdc("aux cleared", AUX_OFFSET, 8'h00);
		rdc("ctrl undoubled", CTRL_OFFSET, 8'h83);
		gap("rc undoubled gap", 2 * RP);
		do_reset(1'b1, 1'b1, SRC_XTAL_HIGH, n);
		cmp("crystal wake", 16'h0001, in_range(n, 1023 * XP + XS));
		rdc("trim reload", TRIM_OFFSET, 8'h2A);
		gap("crystal gap", XP);
		wr(TRIM_OFFSET, 8'h6A);
		cmp("oe crystal active", 16'h0000, 16'(oe));
		wr(CTRL_OFFSET, 8'h0A);
		wait_done;
		gap("crystal low gap", XP);
		wr(CTRL_OFFSET, 8'h0E);
		wait_done;
		cmp("oe rc again", 16'h0001, 16'(oe));
		gap("spare code gap", RP);
	endtask : t_trim_keep

	// the tests need about 11000 cycles; 50000 are allowed
	initial
	begin
		#400us;
		errors++;
		test_done;
	end

	initial
	begin
		t_reset;
		t_divider;
		t_clock_out;
		t_switch;
		t_trim_keep;
		test_done;
	end

endmodule : system_clock_generation_tb
